// ==== core/i2c_hold_abort_pkg.sv ====
package i2c_hold_abort_pkg;

  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] ALL_IRQ_CLEAR_OFS = 8'h40;
  localparam logic [ADDR_W-1:0] ABORT_CLEAR_OFS = 8'h54;
  localparam logic [ADDR_W-1:0] SDA_HOLD_TIMING_OFS = 8'h7C;
  localparam logic [ADDR_W-1:0] TRANSMIT_ABORT_CAUSE_OFS = 8'h80;
  localparam logic [ADDR_W-1:0] STUCK_LOW_LIMIT_OFS = 8'hAC;

  localparam logic [31:0] SDA_HOLD_TIMING_RESET = 32'h0000_0002;
  localparam logic [31:0] TRANSMIT_ABORT_CAUSE_RESET = 32'h0000_0000;

  localparam int TX_HOLD_W = 16;
  localparam int RX_HOLD_LSB = 16;
  localparam int RX_HOLD_W = 8;

  localparam logic [TX_HOLD_W-1:0] MASTER_MIN_HOLD = 16'h0001;
  localparam logic [TX_HOLD_W-1:0] SLAVE_MIN_HOLD = 16'h0007;

  localparam int CAUSE_W = 21;
  localparam int FLUSH_LSB = 23;
  localparam int FLUSH_W = 9;

  localparam int B_HIGHSPEED_NO_RESTART = 8;
  localparam int B_STARTBYTE_NO_RESTART = 9;
  localparam int B_TENBIT_READ_NO_RESTART = 10;
  localparam int B_MASTER_OFF_FAULT = 11;
  localparam int B_ARBITRATION_LOST = 12;
  localparam int B_SLAVE_STALE_FLUSH = 13;
  localparam int B_SLAVE_BUS_LOST = 14;
  localparam int B_SLAVE_READ_TX_FAULT = 15;
  localparam int B_SOFTWARE_ABORT = 16;
  localparam int B_DATA_LINE_STUCK = 17;
  localparam int B_DEVID_NAK = 18;
  localparam int B_DEVID_ADDR_NAK = 19;
  localparam int B_DEVID_WRITE_FAULT = 20;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Levels taken from the enable, control and target-address registers
  typedef struct packed {
    logic enable;
    logic abort_req;
    logic restart_allow;
    logic command_sel_a;
    logic gencall_or_startbyte_sel;
    logic master_mode;
    logic master_enabled;
    logic receiver;
    logic tx_fifo_has_write;
  } ctrl_cfg_t;

  // One-cycle pulses from the master and slave state machines
  typedef struct packed {
    logic master_start;
    logic devid_start;
    logic devid_addr_nak;
    logic devid_nak;
    logic slave_read_tx;
    logic slave_bus_lost;
    logic slave_read_stale;
    logic master_arb_lost;
    logic tenbit_read;
    logic startbyte_send;
    logic highspeed_send;
    logic flushed_command;
  } machine_event_t;

endpackage

// ==== core/i2c_sda_hold_and_abort_source.sv ====
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
// Overview of operation
// (RQ1) Hold register writes land only while the controller is disabled.
// (RQ2) Hold fields count core cycles from SCL fall to the SDA change.
// (RQ3) Transmit hold below the mode minimum (1 master, 7 slave) is raised.
// (RQ4) Software keeps transmit hold at most SCL low length minus 2.
// (RQ5) Receive hold field sits read-write in bits 23:16.
// (RQ6) Transmit hold sits in bits 15:0 and resets to two cycles.
// (RQ7) Reading either clear register clears every cause bit, bit 9 included.
// (RQ8) Bit 9 reasserts one cycle after a clear while its cause remains.
// (RQ9) Bits 31:23 count flushed commands; cleared while disabled.
// (RQ10) Master sets bit 20 on device-id start with write commands queued.
// (RQ11) Master sets bit 19 when the device-id slave address is not acked.
// (RQ12) Master sets bit 18 when the device identifier is not acked.
// (RQ13) Master sets bit 17 when SDA stays low for the stuck limit.
// (RQ14) Master sets bit 16 on a software abort request.
// (RQ15) Bit 15 marks a slave made to transmit in read mode.
// (RQ16) Slave transmitter losing the bus sets bits 14 and 12 together.
// (RQ17) Slave read with stale transmit data sets bit 13 and raises abort.
// (RQ18) Master arbitration loss sets bit 12.
// (RQ19) Master start while master mode is disabled sets bit 11.
// (RQ20) Ten-bit read without restart allowed sets bit 10.
// (RQ21) Start byte without restart allowed sets bit 9.
// (RQ22) High-speed transfer without restart allowed sets bit 8.
module i2c_sda_hold_and_abort_source
  import i2c_hold_abort_pkg::*;
#(
  parameter int unsigned STUCK_LIMIT_DEFAULT = 32'h0010_0000
)
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire reg_req_t i_reg,
  output logic [31:0] o_rd_data,
  input wire ctrl_cfg_t i_cfg,
  input wire machine_event_t i_evt,
  input wire logic i_sda_drive,
  input wire logic i_sda_bit,
  input wire logic i_scl_in,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_transmit_abort_flag,
  output logic [31:0] o_abort_cause
);

  if (STUCK_LIMIT_DEFAULT == 0)
  begin : g_limit_check
    $error("STUCK_LIMIT_DEFAULT must be non-zero");
  end

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic hold_armed;
    logic [TX_HOLD_W-1:0] hold_cnt;
    logic sda_low;
    logic [TX_HOLD_W-1:0] tx_hold;
    logic [RX_HOLD_W-1:0] rx_hold;
    logic [31:0] stuck_limit;
    logic [31:0] stuck_cnt;
    logic [CAUSE_W-1:0] cause;
    logic [FLUSH_W-1:0] flush_cnt;
    logic reassert;
    logic abort_flag;
    logic [31:0] rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic scl_fall;
  logic [TX_HOLD_W-1:0] tx_eff;
  logic [TX_HOLD_W-1:0] hold_len;
  logic clear_rd;
  logic sbyte_live;
  logic stuck_hit;
  logic [CAUSE_W-1:0] ev;
  logic [FLUSH_W-1:0] flush_base;
  logic [31:0] cause_word;

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a, input state_t s);
    logic [31:0] w;
    w = '0;
    unique case (a)
      SDA_HOLD_TIMING_OFS:
      begin
        w[TX_HOLD_W-1:0] = s.tx_hold;
        w[RX_HOLD_LSB +: RX_HOLD_W] = s.rx_hold;
      end
      TRANSMIT_ABORT_CAUSE_OFS:
      begin
        w[CAUSE_W-1:0] = s.cause;
        w[FLUSH_LSB +: FLUSH_W] = s.flush_cnt;
      end
      STUCK_LOW_LIMIT_OFS: w = s.stuck_limit;
      default: w = '0;
    endcase
    return w;
  endfunction

  assign scl_fall = s_r.scl_prev & ~s_r.scl_sync[1];
  // Too small a value would violate the bus hold time, so the minimum wins
  assign tx_eff = i_cfg.master_mode ?
                  ((s_r.tx_hold > MASTER_MIN_HOLD) ? s_r.tx_hold : MASTER_MIN_HOLD) :
                  ((s_r.tx_hold > SLAVE_MIN_HOLD) ? s_r.tx_hold : SLAVE_MIN_HOLD); // see RQ3
  assign hold_len = i_cfg.receiver ? {8'h00, s_r.rx_hold} : tx_eff; // see RQ2
  assign clear_rd = i_reg.rd &
                    ((i_reg.addr == ABORT_CLEAR_OFS) || (i_reg.addr == ALL_IRQ_CLEAR_OFS));
  assign sbyte_live = ~i_cfg.restart_allow & i_cfg.command_sel_a &
                      i_cfg.gencall_or_startbyte_sel;
  assign stuck_hit = i_cfg.master_mode & i_cfg.enable & ~s_r.sda_sync[1] &
                     (s_r.stuck_cnt + 32'h0000_0001 == s_r.stuck_limit); // see RQ13

  always_comb
  begin
    ev = '0;
    ev[B_DEVID_WRITE_FAULT] = i_cfg.master_mode & i_evt.devid_start &
                              i_cfg.tx_fifo_has_write; // see RQ10
    ev[B_DEVID_ADDR_NAK] = i_cfg.master_mode & i_evt.devid_addr_nak; // see RQ11
    ev[B_DEVID_NAK] = i_cfg.master_mode & i_evt.devid_nak; // see RQ12
    ev[B_DATA_LINE_STUCK] = stuck_hit; // see RQ13
    ev[B_SOFTWARE_ABORT] = i_cfg.master_mode & i_cfg.abort_req; // see RQ14
    ev[B_SLAVE_READ_TX_FAULT] = ~i_cfg.master_mode & i_evt.slave_read_tx; // see RQ15
    ev[B_SLAVE_BUS_LOST] = i_evt.slave_bus_lost; // see RQ16
    ev[B_SLAVE_STALE_FLUSH] = i_evt.slave_read_stale; // see RQ17
    ev[B_ARBITRATION_LOST] = i_evt.master_arb_lost | i_evt.slave_bus_lost; // see RQ18
    ev[B_MASTER_OFF_FAULT] = i_evt.master_start & ~i_cfg.master_enabled; // see RQ19
    ev[B_TENBIT_READ_NO_RESTART] = i_evt.tenbit_read & ~i_cfg.restart_allow; // see RQ20
    ev[B_STARTBYTE_NO_RESTART] = i_evt.startbyte_send & ~i_cfg.restart_allow; // see RQ21
    ev[B_HIGHSPEED_NO_RESTART] = i_evt.highspeed_send & ~i_cfg.restart_allow; // see RQ22
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.scl_sync = {s_r.scl_sync[0], i_scl_in};
    s_nxt.sda_sync = {s_r.sda_sync[0], i_sda_in};
    s_nxt.scl_prev = s_r.scl_sync[1];

    // Hold counter starts on the synchronised SCL fall
    if (!i_cfg.enable)
    begin
      s_nxt.hold_armed = 1'b0;
      s_nxt.sda_low = 1'b0;
    end
    else if (scl_fall)
    begin
      s_nxt.hold_armed = 1'b1;
      s_nxt.hold_cnt = hold_len; // see RQ2
    end
    else if (s_r.hold_armed)
    begin
      if (s_r.hold_cnt <= 16'h0001)
      begin
        s_nxt.hold_armed = 1'b0;
        s_nxt.sda_low = i_sda_drive & ~i_sda_bit; // see RQ2
      end
      else
      begin
        s_nxt.hold_cnt = s_r.hold_cnt - 16'h0001;
      end
    end

    // Timing is frozen while the controller runs
    if (i_reg.wr && !i_cfg.enable)
    begin
      if (i_reg.addr == SDA_HOLD_TIMING_OFS)
      begin
        s_nxt.tx_hold = i_reg.wdata[TX_HOLD_W-1:0]; // see RQ1, RQ6
        s_nxt.rx_hold = i_reg.wdata[RX_HOLD_LSB +: RX_HOLD_W]; // see RQ1, RQ5
      end
      if (i_reg.addr == STUCK_LOW_LIMIT_OFS)
      begin
        s_nxt.stuck_limit = i_reg.wdata;
      end
    end

    if (i_cfg.master_mode && i_cfg.enable && !s_r.sda_sync[1])
    begin
      if (s_r.stuck_cnt != s_r.stuck_limit)
      begin
        s_nxt.stuck_cnt = s_r.stuck_cnt + 32'h0000_0001; // see RQ13
      end
    end
    else
    begin
      s_nxt.stuck_cnt = '0;
    end

    // A new cause in the clearing cycle survives the clear
    s_nxt.cause = (clear_rd ? '0 : s_r.cause) | ev; // see RQ7
    s_nxt.cause[B_STARTBYTE_NO_RESTART] = s_nxt.cause[B_STARTBYTE_NO_RESTART] |
                                          s_r.reassert; // see RQ8
    s_nxt.reassert = clear_rd & s_r.cause[B_STARTBYTE_NO_RESTART] & sbyte_live; // see RQ8

    flush_base = (clear_rd || !i_cfg.enable) ? '0 : s_r.flush_cnt; // see RQ9
    if (i_evt.flushed_command && i_cfg.enable && (flush_base != '1))
    begin
      s_nxt.flush_cnt = flush_base + 9'h001; // see RQ9
    end
    else
    begin
      s_nxt.flush_cnt = flush_base;
    end

    s_nxt.abort_flag = |ev; // see RQ17
    s_nxt.rdata = i_reg.rd ? read_word(i_reg.addr, s_r) : '0;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      s_r <= '0;
      s_r.scl_sync <= 2'h3;
      s_r.sda_sync <= 2'h3;
      s_r.scl_prev <= 1'b1;
      s_r.tx_hold <= SDA_HOLD_TIMING_RESET[TX_HOLD_W-1:0]; // see RQ6
      s_r.rx_hold <= SDA_HOLD_TIMING_RESET[RX_HOLD_LSB +: RX_HOLD_W];
      s_r.stuck_limit <= 32'(STUCK_LIMIT_DEFAULT);
      s_r.cause <= TRANSMIT_ABORT_CAUSE_RESET[CAUSE_W-1:0];
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign cause_word = {s_r.flush_cnt, 2'h0, s_r.cause};
  assign o_rd_data = s_r.rdata;
  // Open drain: only ever pulls low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = s_r.sda_low;
  assign o_transmit_abort_flag = s_r.abort_flag;
  assign o_abort_cause = cause_word;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_hold_locked;
    i_reg.wr && i_cfg.enable && i_reg.addr == SDA_HOLD_TIMING_OFS
    |=> $stable(s_r.tx_hold) && $stable(s_r.rx_hold);
  endproperty
  a_hold_locked: assert property (p_hold_locked) else $error("hold not locked"); // see RQ1

  property p_rx_field;
    i_reg.wr && !i_cfg.enable && i_reg.addr == SDA_HOLD_TIMING_OFS
    |=> s_r.rx_hold == $past(i_reg.wdata[23:16]);
  endproperty
  a_rx_field: assert property (p_rx_field) else $error("receive hold not stored"); // see RQ5

  property p_hold_steady;
    i_cfg.enable && s_r.hold_armed && s_r.hold_cnt > 16'h0001 && !scl_fall
    |=> $stable(s_r.sda_low);
  endproperty
  a_hold_steady: assert property (p_hold_steady) else $error("SDA moved inside hold"); // see RQ2

  property p_clear;
    clear_rd && ev == '0 |=> (s_r.cause & ~21'h000200) == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("cause not cleared by read"); // see RQ7

  sequence s_sbyte_drop;
    ##1 !s_r.cause[B_STARTBYTE_NO_RESTART];
  endsequence
  sequence s_sbyte_back;
    ##1 s_r.cause[B_STARTBYTE_NO_RESTART];
  endsequence
  property p_sbyte_reassert;
    clear_rd && s_r.cause[B_STARTBYTE_NO_RESTART] && sbyte_live && !ev[9]
    |-> s_sbyte_drop ##0 s_sbyte_back;
  endproperty
  a_sbyte_reassert: assert property (p_sbyte_reassert) else $error("bit 9 not back"); // see RQ8

  property p_flush_off;
    !i_cfg.enable |=> s_r.flush_cnt == '0;
  endproperty
  a_flush_off: assert property (p_flush_off) else $error("flush count kept while off"); // see RQ9

  property p_slave_lost;
    i_evt.slave_bus_lost |=> s_r.cause[14] && s_r.cause[12];
  endproperty
  a_slave_lost: assert property (p_slave_lost) else $error("bits 14 and 12 not set"); // see RQ16

  property p_stale;
    i_evt.slave_read_stale |=> s_r.cause[13] && o_transmit_abort_flag;
  endproperty
  a_stale: assert property (p_stale) else $error("stale flush not flagged"); // see RQ17

  property p_user_abort;
    i_cfg.master_mode && i_cfg.abort_req |=> s_r.cause[16];
  endproperty
  a_user_abort: assert property (p_user_abort) else $error("software abort lost"); // see RQ14

  property p_sbyte_set;
    i_evt.startbyte_send && !i_cfg.restart_allow |=> s_r.cause[9];
  endproperty
  a_sbyte_set: assert property (p_sbyte_set) else $error("start byte cause lost"); // see RQ21

  property p_tx_minimum;
    i_cfg.enable && scl_fall && !i_cfg.receiver && !i_cfg.master_mode
    |=> s_r.hold_cnt >= SLAVE_MIN_HOLD;
  endproperty
  a_tx_minimum: assert property (p_tx_minimum) else $error("slave hold below seven"); // see RQ3

  property p_devid_write;
    i_cfg.master_mode && i_evt.devid_start && i_cfg.tx_fifo_has_write
    |=> s_r.cause[B_DEVID_WRITE_FAULT];
  endproperty
  a_devid_write: assert property (p_devid_write) else $error("bit 20 not set"); // see RQ10

  property p_devid_addr;
    i_cfg.master_mode && i_evt.devid_addr_nak |=> s_r.cause[B_DEVID_ADDR_NAK];
  endproperty
  a_devid_addr: assert property (p_devid_addr) else $error("bit 19 not set"); // see RQ11

  property p_devid_nak;
    i_cfg.master_mode && i_evt.devid_nak |=> s_r.cause[B_DEVID_NAK];
  endproperty
  a_devid_nak: assert property (p_devid_nak) else $error("bit 18 not set"); // see RQ12

  property p_stuck;
    i_cfg.master_mode && i_cfg.enable && !s_r.sda_sync[1] &&
    s_r.stuck_cnt == s_r.stuck_limit - 32'h0000_0001 |=> s_r.cause[B_DATA_LINE_STUCK];
  endproperty
  a_stuck: assert property (p_stuck) else $error("bit 17 not set"); // see RQ13

  property p_rd_tx;
    !i_cfg.master_mode && i_evt.slave_read_tx |=> s_r.cause[B_SLAVE_READ_TX_FAULT];
  endproperty
  a_rd_tx: assert property (p_rd_tx) else $error("bit 15 not set"); // see RQ15

  property p_rd_tx_quiet;
    $rose(s_r.cause[B_SLAVE_READ_TX_FAULT]) |-> $past(i_evt.slave_read_tx);
  endproperty
  a_rd_tx_quiet: assert property (p_rd_tx_quiet) else $error("bit 15 unprompted"); // see RQ15

  property p_arb_lost;
    i_evt.master_arb_lost |=> s_r.cause[B_ARBITRATION_LOST];
  endproperty
  a_arb_lost: assert property (p_arb_lost) else $error("bit 12 not set"); // see RQ18

  property p_master_off;
    i_evt.master_start && !i_cfg.master_enabled |=> s_r.cause[B_MASTER_OFF_FAULT];
  endproperty
  a_master_off: assert property (p_master_off) else $error("bit 11 not set"); // see RQ19

  property p_tenbit;
    i_evt.tenbit_read && !i_cfg.restart_allow |=> s_r.cause[B_TENBIT_READ_NO_RESTART];
  endproperty
  a_tenbit: assert property (p_tenbit) else $error("bit 10 not set"); // see RQ20

  property p_highspeed;
    i_evt.highspeed_send && !i_cfg.restart_allow |=> s_r.cause[B_HIGHSPEED_NO_RESTART];
  endproperty
  a_highspeed: assert property (p_highspeed) else $error("bit 8 not set"); // see RQ22

endmodule

// ==== testbench/i2c_remote_party.sv ====
`timescale 1ns/1ns
module i2c_remote_party
(
  input wire logic i_go,
  input wire logic i_stuck,
  input wire logic i_dut_oe,
  output logic o_scl,
  output logic o_sda
);
  // Pull-up: the line stays high unless a party pulls it low
  assign o_sda = ~(i_dut_oe | i_stuck);
  initial o_scl = 1'b1;
  // Clock stands high between frames
  always @(posedge i_go)
  begin
    #100 o_scl = 1'b0;
    // Long first low phase leaves room for a slave hold
    #800 o_scl = 1'b1;
    repeat (2)
    begin
      #160 o_scl = 1'b0;
      #160 o_scl = 1'b1;
    end
  end
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import i2c_hold_abort_pkg::*;
  typedef struct packed {logic [11:0] e; logic [8:0] c; logic [31:0] x;} row_t;
  localparam logic [8:0] BASE = 9'h144;
  logic i_sys_clk, i_sys_rst, drv, bit_v, go, stuck, scl, sda, oe, flag, sda_out;
  reg_req_t req;
  ctrl_cfg_t cfg;
  machine_event_t evt;
  logic [31:0] rd_data, cause, got;
  int bad_count, checks_done, n;
  row_t rows [16] = '{
    {12'h400, 9'h14D, 32'h0010_0000},
    {12'h200, 9'h14C, 32'h0008_0000},
    {12'h100, 9'h14C, 32'h0004_0000},
    {12'h000, 9'h1CC, 32'h0001_0000},
    {12'h080, 9'h144, 32'h0000_8000},
    {12'h040, 9'h144, 32'h0000_5000},
    {12'h020, 9'h144, 32'h0000_2000},
    {12'h010, 9'h14C, 32'h0000_1000},
    {12'h800, 9'h140, 32'h0000_0800},
    {12'h008, 9'h104, 32'h0000_0400},
    {12'h004, 9'h104, 32'h0000_0200},
    {12'h002, 9'h104, 32'h0000_0100},
    {12'h008, 9'h144, 32'h0000_0000},
    {12'h800, 9'h144, 32'h0000_0000},
    {12'h400, 9'h145, 32'h0000_0000},
    {12'h080, 9'h14C, 32'h0000_0000}
  };
  // Stuck limit shortened so the timeout fits a short run
  i2c_sda_hold_and_abort_source #(.STUCK_LIMIT_DEFAULT(20)) i_dut (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_reg(req), .o_rd_data(rd_data),
    .i_cfg(cfg), .i_evt(evt), .i_sda_drive(drv), .i_sda_bit(bit_v), .i_scl_in(scl),
    .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(oe), .o_transmit_abort_flag(flag),
    .o_abort_cause(cause));
  i2c_remote_party i_far (.i_go(go), .i_stuck(stuck), .i_dut_oe(oe), .o_scl(scl), .o_sda(sda));
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task chk_span(input string nm, input int lo, input int hi, input int seen);
    checks_done++;
    if (seen < lo || seen > hi)
    begin
      bad_count++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk) req <= {a, d, 2'b10};
    @(posedge i_sys_clk) req.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge i_sys_clk) req <= {a, 32'h0000_0000, 2'b01};
    @(posedge i_sys_clk) req.rd <= 1'b0;
    #1 got = rd_data;
  endtask
  task hold_case(input logic [8:0] c, input logic b, input int lo, input int hi);
    logic start;
    @(posedge i_sys_clk) cfg <= c;
    bit_v <= b;
    drv <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1 start = oe;
    n = 0;
    go = 1'b1;
    while (oe === start && n < 40)
    begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    if (n >= 40)
    begin
      bad_count++;
      close_out();
    end
    chk_span("hold", lo, hi, n);
    chk("sda out", 32'h0000_0000, {31'h0, sda_out});
    go = 1'b0;
    repeat (50) @(posedge i_sys_clk);
  endtask
  initial
  begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  initial
  begin
    repeat (100000) @(posedge i_sys_clk);
    bad_count++;
    close_out();
  end
  initial
  begin
    i_sys_rst = 1'b1;
    req = '0;
    cfg = BASE;
    evt = '0;
    drv = 1'b0;
    bit_v = 1'b0;
    go = 1'b0;
    stuck = 1'b0;
    repeat (10) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge i_sys_clk) evt <= rows[i].e;
      cfg <= rows[i].c;
      @(posedge i_sys_clk) evt <= '0;
      cfg <= BASE;
      #1 chk("cause", rows[i].x, cause);
      chk("flag", {31'h0, |rows[i].x}, {31'h0, flag});
      rd(i[0] ? ALL_IRQ_CLEAR_OFS : ABORT_CLEAR_OFS);
      chk("cleared", 32'h0000_0000, cause);
    end
    // Second reset in mid-run with the controller disabled
    @(posedge i_sys_clk) i_sys_rst <= 1'b1;
    cfg <= 9'h044;
    repeat (10) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    rd(SDA_HOLD_TIMING_OFS);
    chk("hold reset", 32'h0000_0002, got);
    rd(TRANSMIT_ABORT_CAUSE_OFS);
    chk("cause reset", 32'h0000_0000, got);
    wr(STUCK_LOW_LIMIT_OFS, 32'h0000_0014);
    rd(STUCK_LOW_LIMIT_OFS);
    chk("stuck limit", 32'h0000_0014, got);
    wr(SDA_HOLD_TIMING_OFS, 32'hFFFF_FFFF);
    rd(SDA_HOLD_TIMING_OFS);
    chk("hold fields", 32'h00FF_FFFF, got);
    @(posedge i_sys_clk) cfg <= BASE;
    wr(SDA_HOLD_TIMING_OFS, 32'h0000_0005);
    rd(SDA_HOLD_TIMING_OFS);
    chk("hold locked", 32'h00FF_FFFF, got);
    wr(TRANSMIT_ABORT_CAUSE_OFS, 32'hFFFF_FFFF);
    rd(8'h10);
    chk("unmapped", 32'h0000_0000, got);
    rd(TRANSMIT_ABORT_CAUSE_OFS);
    chk("cause ro", 32'h0000_0000, got);
    // Start byte cause kept alive while the clear is attempted
    @(posedge i_sys_clk) cfg <= 9'h134;
    evt <= 12'h004;
    @(posedge i_sys_clk) evt <= '0;
    rd(ALL_IRQ_CLEAR_OFS);
    chk("bit9 drop", 32'h0000_0000, {31'h0, cause[9]});
    @(posedge i_sys_clk);
    #1 chk("bit9 back", 32'h0000_0001, {31'h0, cause[9]});
    @(posedge i_sys_clk) cfg <= BASE;
    rd(ABORT_CLEAR_OFS);
    @(posedge i_sys_clk);
    #1 chk("bit9 gone", 32'h0000_0000, {31'h0, cause[9]});
    @(posedge i_sys_clk) evt <= 12'h001;
    repeat (3) @(posedge i_sys_clk);
    evt <= '0;
    rd(TRANSMIT_ABORT_CAUSE_OFS);
    chk("flush count", 32'h0180_0000, got);
    @(posedge i_sys_clk) cfg <= 9'h044;
    repeat (2) @(posedge i_sys_clk);
    #1 chk("flush off", 32'h0000_0000, {23'h0, cause[31:23]});
    @(posedge i_sys_clk) cfg <= 9'h14C;
    stuck <= 1'b1;
    repeat (30) @(posedge i_sys_clk);
    stuck <= 1'b0;
    @(posedge i_sys_clk);
    #1 chk("stuck", 32'h0002_0000, cause & 32'h0002_0000);
    @(posedge i_sys_clk) cfg <= 9'h044;
    wr(SDA_HOLD_TIMING_OFS, 32'h0001_0002);
    // Pin to detect is about three cycles of sync on top of the hold
    hold_case(9'h144, 1'b0, 11, 14);
    hold_case(9'h14C, 1'b1, 6, 9);
    hold_case(9'h146, 1'b0, 5, 8);
    close_out();
  end
endmodule
